// ### rtl/srfa_alu.sv
// Shift, rotate, nibble exchange, bit transfer and status flag slice of the core
// Behaviour
// - shift left: zero into bit 0; Z,C,N,V
// - shift right: zero into bit 7; Z,C,N,V
// - rotate left through carry; Z,C,N,V
// - rotate right through carry; Z,C,N,V
// - arithmetic right shift keeps bit 7; Z,C,N,V
// - nibble exchange swaps halves, flags untouched
// - bit set/clear writes selected status flag
// - copy selected source bit into transfer flag
// - transfer flag written into destination bit
// - set/clear carry flag only
// - set/clear negative flag
// - set/clear zero flag
// - set/clear global interrupt enable flag
// - set/clear signed test flag
// - set/clear overflow flag
// - set/clear transfer flag
// - set/clear half carry flag
`timescale 1ns/100ps
`default_nettype none
module srfa_alu #(
    parameter int DATA_W = srfa_pkg::DATA_W,
    parameter int SEL_W  = srfa_pkg::SEL_W,
    parameter int REG_AW = srfa_pkg::REG_AW
) (
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               resetn_i,
    // Instruction from the decoder
    input  wire logic               op_valid_i,
    input  wire srfa_pkg::srfa_op_t op_i,
    input  wire logic [SEL_W-1:0]   bit_sel_i,
    input  wire logic [REG_AW-1:0]  dest_addr_i,
    // Operands from the register file
    input  wire logic [DATA_W-1:0]  dest_data_i,
    input  wire logic [DATA_W-1:0]  source_operand_i,
    // Direct status load by the core
    input  wire logic               status_load_i,
    input  wire logic [DATA_W-1:0]  status_load_data_i,
    // Register file write back
    output logic                    dest_wr_o,
    output logic      [REG_AW-1:0]  dest_wr_addr_o,
    output logic      [DATA_W-1:0]  dest_wr_data_o,
    // Status and completion
    output logic      [DATA_W-1:0]  status_flags_register_o,
    output logic                    irq_enable_o,
    output logic                    op_done_o,
    output logic                    op_illegal_o
);

    // One-hot mask of a flag position, shared by every instruction flag write path
    function automatic logic [DATA_W-1:0] flag_mask(input logic [SEL_W-1:0] pos);
        flag_mask = '0;
        flag_mask[pos] = 1'b1;
    endfunction

    logic [DATA_W-1:0] shift_result;
    logic              shift_carry;
    logic              shift_neg;
    logic              shift_zero;
    logic              shift_ovf;

    logic [DATA_W-1:0] next_flag_en;
    logic [DATA_W-1:0] next_flag_val;
    logic [DATA_W-1:0] next_dest_data;
    logic              next_dest_wr;
    logic              next_illegal;

    logic [DATA_W-1:0] flag_en;
    logic [DATA_W-1:0] flag_val;
    logic [DATA_W-1:0] znvc_mask;
    logic [DATA_W-1:0] znvc_val;

    srfa_shifter #(
        .DATA_W (DATA_W)
    ) u_shifter (
        .op_i      (op_i),
        .operand_i (dest_data_i),
        .carry_i   (status_flags_register_o[srfa_pkg::FLAG_C]),
        .result_o  (shift_result),
        .carry_o   (shift_carry),
        .neg_o     (shift_neg),
        .zero_o    (shift_zero),
        .ovf_o     (shift_ovf)
    );

    // Shifts touch only Z, C, N and V; S and H keep their value
    always_comb
    begin
        znvc_mask = flag_mask(srfa_pkg::FLAG_Z) | flag_mask(srfa_pkg::FLAG_C)
                  | flag_mask(srfa_pkg::FLAG_N) | flag_mask(srfa_pkg::FLAG_V);
        znvc_val                   = '0;
        znvc_val[srfa_pkg::FLAG_Z] = shift_zero;
        znvc_val[srfa_pkg::FLAG_C] = shift_carry;
        znvc_val[srfa_pkg::FLAG_N] = shift_neg;
        znvc_val[srfa_pkg::FLAG_V] = shift_ovf;
    end

    // Operation decode: destination write and status flag write per operation
    always_comb
    begin
        next_flag_en   = '0;
        next_flag_val  = '0;
        next_dest_data = dest_data_i;
        next_dest_wr   = 1'b0;
        next_illegal   = 1'b0;
        if (op_valid_i)
        begin
            case (op_i)
                srfa_pkg::SRFA_OP_NOP:
                begin
                    next_dest_wr = 1'b0;
                end
                srfa_pkg::SRFA_OP_SHL,
                srfa_pkg::SRFA_OP_SHR,
                srfa_pkg::SRFA_OP_ROTL,
                srfa_pkg::SRFA_OP_ROTR,
                srfa_pkg::SRFA_OP_SHRA:
                begin
                    next_dest_data = shift_result;
                    next_dest_wr   = 1'b1;
                    next_flag_en   = znvc_mask;
                    next_flag_val  = znvc_val;
                end
                srfa_pkg::SRFA_OP_NIBX:
                begin
                    next_dest_data = {dest_data_i[3:0], dest_data_i[7:4]};
                    next_dest_wr   = 1'b1;
                end
                srfa_pkg::SRFA_OP_BITSET:
                begin
                    next_flag_en  = flag_mask(bit_sel_i);
                    next_flag_val = '1;
                end
                srfa_pkg::SRFA_OP_BITCLR:
                begin
                    next_flag_en  = flag_mask(bit_sel_i);
                    next_flag_val = '0;
                end
                srfa_pkg::SRFA_OP_TOXFER:
                begin
                    next_flag_en                   = flag_mask(srfa_pkg::FLAG_T);
                    next_flag_val[srfa_pkg::FLAG_T] = source_operand_i[bit_sel_i];
                end
                srfa_pkg::SRFA_OP_FRXFER:
                begin
                    next_dest_data[bit_sel_i] = status_flags_register_o[srfa_pkg::FLAG_T];
                    next_dest_wr              = 1'b1;
                end
                srfa_pkg::SRFA_OP_SETC:
                begin
                    next_flag_en  = flag_mask(srfa_pkg::FLAG_C);
                    next_flag_val = '1;
                end
                srfa_pkg::SRFA_OP_CLRC:
                begin
                    next_flag_en  = flag_mask(srfa_pkg::FLAG_C);
                    next_flag_val = '0;
                end
                srfa_pkg::SRFA_OP_SETN:
                begin
                    next_flag_en  = flag_mask(srfa_pkg::FLAG_N);
                    next_flag_val = '1;
                end
                srfa_pkg::SRFA_OP_CLRN:
                begin
                    next_flag_en  = flag_mask(srfa_pkg::FLAG_N);
                    next_flag_val = '0;
                end
                srfa_pkg::SRFA_OP_SETZ:
                begin
                    next_flag_en  = flag_mask(srfa_pkg::FLAG_Z);
                    next_flag_val = '1;
                end
                srfa_pkg::SRFA_OP_CLRZ:
                begin
                    next_flag_en  = flag_mask(srfa_pkg::FLAG_Z);
                    next_flag_val = '0;
                end
                srfa_pkg::SRFA_OP_IRQ_ON:
                begin
                    next_flag_en  = flag_mask(srfa_pkg::FLAG_I);
                    next_flag_val = '1;
                end
                srfa_pkg::SRFA_OP_IRQ_OFF:
                begin
                    next_flag_en  = flag_mask(srfa_pkg::FLAG_I);
                    next_flag_val = '0;
                end
                srfa_pkg::SRFA_OP_SETS:
                begin
                    next_flag_en  = flag_mask(srfa_pkg::FLAG_S);
                    next_flag_val = '1;
                end
                srfa_pkg::SRFA_OP_CLRS:
                begin
                    next_flag_en  = flag_mask(srfa_pkg::FLAG_S);
                    next_flag_val = '0;
                end
                srfa_pkg::SRFA_OP_SETV:
                begin
                    next_flag_en  = flag_mask(srfa_pkg::FLAG_V);
                    next_flag_val = '1;
                end
                srfa_pkg::SRFA_OP_CLRV:
                begin
                    next_flag_en  = flag_mask(srfa_pkg::FLAG_V);
                    next_flag_val = '0;
                end
                srfa_pkg::SRFA_OP_SETT:
                begin
                    next_flag_en  = flag_mask(srfa_pkg::FLAG_T);
                    next_flag_val = '1;
                end
                srfa_pkg::SRFA_OP_CLRT:
                begin
                    next_flag_en  = flag_mask(srfa_pkg::FLAG_T);
                    next_flag_val = '0;
                end
                srfa_pkg::SRFA_OP_SETH:
                begin
                    next_flag_en  = flag_mask(srfa_pkg::FLAG_H);
                    next_flag_val = '1;
                end
                srfa_pkg::SRFA_OP_CLRH:
                begin
                    next_flag_en  = flag_mask(srfa_pkg::FLAG_H);
                    next_flag_val = '0;
                end
                default:
                begin
                    // Unknown codes change nothing, only report themselves
                    next_illegal = 1'b1;
                end
            endcase
        end
    end

    // A core load of the whole status word yields per bit to the instruction,
    // so a flag written by the current operation is never lost
    always_comb
    begin
        flag_en  = next_flag_en;
        flag_val = next_flag_val;
        if (status_load_i)
        begin
            flag_en  = '1;
            flag_val = (next_flag_val & next_flag_en) | (status_load_data_i & ~next_flag_en);
        end
    end

    srfa_status #(
        .DATA_W  (DATA_W),
        .RST_VAL (srfa_pkg::STATUS_RESET)
    ) u_status (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .wr_en_i  (flag_en),
        .wr_val_i (flag_val),
        .flags_o  (status_flags_register_o)
    );

    // Result is registered on the same edge as the flags: ready next cycle
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            dest_wr_data_o <= srfa_pkg::RESULT_RESET;
            dest_wr_addr_o <= '0;
        end
        else if (next_dest_wr)
        begin
            dest_wr_data_o <= next_dest_data;
            dest_wr_addr_o <= dest_addr_i;
        end
    end

    // Write strobe and completion pulses, one cycle each
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            dest_wr_o    <= 1'b0;
            op_done_o    <= 1'b0;
            op_illegal_o <= 1'b0;
        end
        else
        begin
            dest_wr_o    <= next_dest_wr;
            op_done_o    <= op_valid_i && !next_illegal;
            op_illegal_o <= next_illegal;
        end
    end

    // Interrupt gate follows the I flag directly
    assign irq_enable_o = status_flags_register_o[srfa_pkg::FLAG_I];

endmodule
`default_nettype wire

// ### rtl/srfa_pkg.sv
// Shared constants, flag layout and operation codes for the shift/rotate/flag slice
package srfa_pkg;

    localparam int DATA_W = 8;
    localparam int SEL_W  = 3;
    localparam int REG_AW = 5;

    // Status flag positions, bit 7 down to bit 0
    localparam logic [2:0] FLAG_I = 3'h7;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_C = 3'h0;

    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;

    typedef enum logic [4:0] {
        SRFA_OP_NOP     = 5'h00,
        SRFA_OP_SHL     = 5'h01,
        SRFA_OP_SHR     = 5'h02,
        SRFA_OP_ROTL    = 5'h03,
        SRFA_OP_ROTR    = 5'h04,
        SRFA_OP_SHRA    = 5'h05,
        SRFA_OP_NIBX    = 5'h06,
        SRFA_OP_BITSET  = 5'h07,
        SRFA_OP_BITCLR  = 5'h08,
        SRFA_OP_TOXFER  = 5'h09,
        SRFA_OP_FRXFER  = 5'h0a,
        SRFA_OP_SETC    = 5'h0b,
        SRFA_OP_CLRC    = 5'h0c,
        SRFA_OP_SETN    = 5'h0d,
        SRFA_OP_CLRN    = 5'h0e,
        SRFA_OP_SETZ    = 5'h0f,
        SRFA_OP_CLRZ    = 5'h10,
        SRFA_OP_IRQ_ON  = 5'h11,
        SRFA_OP_IRQ_OFF = 5'h12,
        SRFA_OP_SETS    = 5'h13,
        SRFA_OP_CLRS    = 5'h14,
        SRFA_OP_SETV    = 5'h15,
        SRFA_OP_CLRV    = 5'h16,
        SRFA_OP_SETT    = 5'h17,
        SRFA_OP_CLRT    = 5'h18,
        SRFA_OP_SETH    = 5'h19,
        SRFA_OP_CLRH    = 5'h1a
    } srfa_op_t;

    // True for the five operations that move bits through the shifter
    function automatic logic is_shift(input srfa_op_t op);
        is_shift = (op == SRFA_OP_SHL) || (op == SRFA_OP_SHR) || (op == SRFA_OP_ROTL)
                || (op == SRFA_OP_ROTR) || (op == SRFA_OP_SHRA);
    endfunction

endpackage

// ### rtl/srfa_shifter.sv
// Combinational shift and rotate unit with its Z, C, N, V results
`timescale 1ns/100ps
`default_nettype none
module srfa_shifter #(
    parameter int DATA_W = srfa_pkg::DATA_W
) (
    // Operation
    input  wire srfa_pkg::srfa_op_t op_i,
    input  wire logic [DATA_W-1:0]  operand_i,
    input  wire logic               carry_i,
    // Results
    output logic       [DATA_W-1:0] result_o,
    output logic                    carry_o,
    output logic                    neg_o,
    output logic                    zero_o,
    output logic                    ovf_o
);

    always_comb
    begin
        result_o = operand_i;
        carry_o  = carry_i;
        case (op_i)
            srfa_pkg::SRFA_OP_SHL:
            begin
                result_o = {operand_i[DATA_W-2:0], 1'b0};
                carry_o  = operand_i[DATA_W-1];
            end
            srfa_pkg::SRFA_OP_SHR:
            begin
                result_o = {1'b0, operand_i[DATA_W-1:1]};
                carry_o  = operand_i[0];
            end
            srfa_pkg::SRFA_OP_ROTL:
            begin
                result_o = {operand_i[DATA_W-2:0], carry_i};
                carry_o  = operand_i[DATA_W-1];
            end
            srfa_pkg::SRFA_OP_ROTR:
            begin
                result_o = {carry_i, operand_i[DATA_W-1:1]};
                carry_o  = operand_i[0];
            end
            srfa_pkg::SRFA_OP_SHRA:
            begin
                result_o = {operand_i[DATA_W-1], operand_i[DATA_W-1:1]};
                carry_o  = operand_i[0];
            end
            default:
            begin
                result_o = operand_i;
                carry_o  = carry_i;
            end
        endcase
    end

    // Overflow is the sign-versus-carry mismatch left by the move
    assign neg_o  = result_o[DATA_W-1];
    assign zero_o = (result_o == '0);
    assign ovf_o  = neg_o ^ carry_o;

endmodule
`default_nettype wire

// ### rtl/srfa_status.sv
// Status flag register with per-bit write enables
`timescale 1ns/100ps
`default_nettype none
module srfa_status #(
    parameter int         DATA_W  = srfa_pkg::DATA_W,
    parameter logic [7:0] RST_VAL = srfa_pkg::STATUS_RESET
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              resetn_i,
    // Write port
    input  wire logic [DATA_W-1:0] wr_en_i,
    input  wire logic [DATA_W-1:0] wr_val_i,
    // Flags
    output logic      [DATA_W-1:0] flags_o
);

    genvar g;
    generate
        for (g = 0; g < DATA_W; g++)
        begin : g_flag
            always_ff @(posedge clk_i or negedge resetn_i)
            begin
                if (!resetn_i)
                    flags_o[g] <= RST_VAL[g];
                else if (wr_en_i[g])
                    flags_o[g] <= wr_val_i[g];
            end
        end
    endgenerate

endmodule
`default_nettype wire

// ### test/srfa_alu_sva.sv
// Concurrent property checker for the shift, rotate and flag slice
`timescale 1ns/100ps
`default_nettype none
module srfa_alu_sva (
    // Clock, reset and decoder side
    input  wire logic               clk_i,
    input  wire logic               resetn_i,
    input  wire logic               op_valid_i,
    input  wire srfa_pkg::srfa_op_t op_i,
    input  wire logic [2:0]         bit_sel_i,
    input  wire logic [4:0]         dest_addr_i,
    input  wire logic [7:0]         dest_data_i,
    input  wire logic [7:0]         source_operand_i,
    input  wire logic               status_load_i,
    input  wire logic [7:0]         status_load_data_i,
    // Slice outputs
    input  wire logic               dest_wr_o,
    input  wire logic [4:0]         dest_wr_addr_o,
    input  wire logic [7:0]         dest_wr_data_o,
    input  wire logic [7:0]         status_flags_register_o,
    input  wire logic               irq_enable_o,
    input  wire logic               op_done_o,
    input  wire logic               op_illegal_o
);
    logic [7:0] sf;
    logic [7:0] d;
    logic [7:0] r;
    logic [7:0] ld_t;
    logic       src_bit;
    assign sf = status_flags_register_o;
    assign d = dest_data_i;
    assign r = dest_wr_data_o;
    assign src_bit = source_operand_i[bit_sel_i];
    always_comb
    begin
        ld_t = dest_data_i;
        ld_t[bit_sel_i] = status_flags_register_o[6];
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_issue(srfa_pkg::srfa_op_t o);
        op_valid_i && op_i == o;
    endsequence
    sequence s_quiet(srfa_pkg::srfa_op_t o);
        s_issue(o) ##0 !status_load_i;
    endsequence
    sequence s_shift;
        op_valid_i && !status_load_i
            && op_i inside {[srfa_pkg::SRFA_OP_SHL:srfa_pkg::SRFA_OP_SHRA]};
    endsequence

    a_shl_data: assert property (s_issue(srfa_pkg::SRFA_OP_SHL)
        |=> dest_wr_o && r == {$past(d[6:0]), 1'b0} && sf[0] == $past(d[7]))
        else $error("shift left result wrong");
    a_shr_data: assert property (s_issue(srfa_pkg::SRFA_OP_SHR)
        |=> dest_wr_o && r == {1'b0, $past(d[7:1])} && sf[0] == $past(d[0]))
        else $error("shift right result wrong");
    a_rotl_data: assert property (s_issue(srfa_pkg::SRFA_OP_ROTL)
        |=> r == {$past(d[6:0]), $past(sf[0])} && sf[0] == $past(d[7]))
        else $error("rotate left result wrong");
    a_rotr_data: assert property (s_issue(srfa_pkg::SRFA_OP_ROTR)
        |=> r == {$past(sf[0]), $past(d[7:1])} && sf[0] == $past(d[0]))
        else $error("rotate right result wrong");
    a_shra_sign: assert property (s_issue(srfa_pkg::SRFA_OP_SHRA)
        |=> r == {$past(d[7]), $past(d[7:1])} && sf[0] == $past(d[0]))
        else $error("arithmetic shift result wrong");
    a_shift_flags: assert property (s_shift
        |=> sf[3:1] == {r[7] ^ sf[0], r[7], r == 8'h00} && sf[7:4] == $past(sf[7:4]))
        else $error("shift flags wrong");
    a_nibx_swap: assert property (s_quiet(srfa_pkg::SRFA_OP_NIBX)
        |=> dest_wr_o && r == {$past(d[3:0]), $past(d[7:4])} && $stable(sf))
        else $error("nibble exchange wrong");
    a_bit_set: assert property (s_issue(srfa_pkg::SRFA_OP_BITSET)
        |=> sf[$past(bit_sel_i)] && !dest_wr_o)
        else $error("selected flag not set");
    a_bit_clear: assert property (s_issue(srfa_pkg::SRFA_OP_BITCLR)
        |=> !sf[$past(bit_sel_i)] && !dest_wr_o)
        else $error("selected flag not cleared");
    a_to_xfer: assert property (s_quiet(srfa_pkg::SRFA_OP_TOXFER)
        |=> sf == (($past(sf) & 8'hbf) | {1'b0, $past(src_bit), 6'h00}))
        else $error("transfer flag copy wrong");
    a_from_xfer: assert property (s_quiet(srfa_pkg::SRFA_OP_FRXFER)
        |=> dest_wr_o && r == $past(ld_t) && $stable(sf))
        else $error("transfer flag load wrong");
    a_carry_only: assert property (s_quiet(srfa_pkg::SRFA_OP_SETC)
        |=> sf == ($past(sf) | 8'h01))
        else $error("set carry wrong");
    a_irq_mirror: assert property (irq_enable_o == sf[7])
        else $error("interrupt enable differs from flag");
    a_done_next: assert property (op_valid_i && op_i <= 5'h1a
        |=> op_done_o && !op_illegal_o)
        else $error("operation not done in one cycle");
    a_illegal_quiet: assert property (op_valid_i && op_i > 5'h1a && !status_load_i
        |=> op_illegal_o && !dest_wr_o && !op_done_o && $stable(sf))
        else $error("undefined code changed state");
endmodule
bind srfa_alu srfa_alu_sva u_sva (
    .clk_i(clk_i), .resetn_i(resetn_i), .op_valid_i(op_valid_i), .op_i(op_i),
    .bit_sel_i(bit_sel_i), .dest_addr_i(dest_addr_i), .dest_data_i(dest_data_i),
    .source_operand_i(source_operand_i), .status_load_i(status_load_i),
    .status_load_data_i(status_load_data_i), .dest_wr_o(dest_wr_o),
    .dest_wr_addr_o(dest_wr_addr_o), .dest_wr_data_o(dest_wr_data_o),
    .status_flags_register_o(status_flags_register_o), .irq_enable_o(irq_enable_o),
    .op_done_o(op_done_o), .op_illegal_o(op_illegal_o));
`default_nettype wire

// ### test/srfa_regfile_model.sv
// Behavioural register file standing in for the core around the slice
`timescale 1ns/100ps
`default_nettype none
module srfa_regfile_model (
    // Clock
    input  wire logic       clk_i,
    // Operand read, combinational as in the core
    input  wire logic [4:0] rd_addr_i,
    output logic      [7:0] rd_data_o,
    // Write back from the slice
    input  wire logic       wr_i,
    input  wire logic [4:0] wr_addr_i,
    input  wire logic [7:0] wr_data_i
);
    logic [7:0] mem [32];
    assign rd_data_o = mem[rd_addr_i];
    // No forwarding: a write lands one edge after the slice reports it
    always @(posedge clk_i)
    begin
        if (wr_i)
        begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end
    task automatic poke(input logic [4:0] a, input logic [7:0] v);
        mem[a] = v;
    endtask
endmodule
`default_nettype wire

// ### test/test_shift_rotate_flag_alu.sv
// Self-checking bench for the shift, rotate and flag slice
`timescale 1ns/100ps
`default_nettype none
module test_shift_rotate_flag_alu;
    logic               clk_i;
    logic               resetn_i;
    logic               op_valid_i;
    srfa_pkg::srfa_op_t op_i;
    logic [2:0]         bit_sel_i;
    logic [4:0]         addr;
    logic               status_load_i;
    logic [7:0]         load_data;
    logic [7:0]         rd_data;
    logic               dest_wr_o;
    logic [4:0]         dest_wr_addr_o;
    logic [7:0]         dest_wr_data_o;
    logic [7:0]         flags;
    logic               irq_enable_o;
    logic               op_done_o;
    logic               op_illegal_o;
    logic [7:0]         st;
    logic [8:0]         x;
    int                 n_fail;
    int                 n_checks;
    int                 fpos [8] = '{0, 2, 1, 7, 4, 3, 6, 5};

    srfa_alu DUT (.clk_i(clk_i), .resetn_i(resetn_i), .op_valid_i(op_valid_i), .op_i(op_i),
        .bit_sel_i(bit_sel_i), .dest_addr_i(addr), .dest_data_i(rd_data),
        .source_operand_i(rd_data), .status_load_i(status_load_i),
        .status_load_data_i(load_data), .dest_wr_o(dest_wr_o), .dest_wr_addr_o(dest_wr_addr_o),
        .dest_wr_data_o(dest_wr_data_o), .status_flags_register_o(flags),
        .irq_enable_o(irq_enable_o), .op_done_o(op_done_o), .op_illegal_o(op_illegal_o));
    srfa_regfile_model u_rf (.clk_i(clk_i), .rd_addr_i(addr), .rd_data_o(rd_data),
        .wr_i(dest_wr_o), .wr_addr_i(dest_wr_addr_o), .wr_data_i(dest_wr_data_o));

    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", name, e, g);
            n_fail++;
        end
    endtask

    // One decoder request, then the one-cycle answer is compared with the shadow flags st
    task automatic run(input srfa_pkg::srfa_op_t o, input logic [4:0] a, input logic [2:0] s,
                       input logic w, input logic [7:0] ed);
        op_i = o;
        addr = a;
        bit_sel_i = s;
        op_valid_i = 1'b1;
        // Valid stays up for back-to-back calls; callers drop it before an idle edge
        @(posedge clk_i);
        #1;
        chk("done", 8'h01, {7'h0, op_done_o});
        chk("write strobe", {7'h0, w}, {7'h0, dest_wr_o});
        if (w)
        begin
            chk("result", ed, dest_wr_data_o);
            chk("write address", {3'h0, a}, {3'h0, dest_wr_addr_o});
        end
        chk("flags", st, flags);
        chk("irq enable", {7'h0, st[7]}, {7'h0, irq_enable_o});
    endtask

    function automatic logic [8:0] shf(input int k, input logic [7:0] v, input logic c);
        case (k)
            0: shf = {v[7], v[6:0], 1'b0};
            1: shf = {v[0], 1'b0, v[7:1]};
            2: shf = {v[7], v[6:0], c};
            3: shf = {v[0], c, v[7:1]};
            default: shf = {v[0], v[7], v[7:1]};
        endcase
    endfunction

    initial
    begin
        resetn_i = 1'b0;
        op_valid_i = 1'b0;
        op_i = srfa_pkg::SRFA_OP_NOP;
        bit_sel_i = 3'h0;
        addr = 5'h00;
        status_load_i = 1'b0;
        load_data = 8'h00;
        n_fail = 0;
        n_checks = 0;
        st = 8'h00;
        repeat (8) @(posedge clk_i);
        #1 resetn_i = 1'b1;
        chk("reset flags", 8'h00, flags);
        $display("test reset done");
        for (int i = 0; i < 10; i++)
        begin
            st[0] = i[0];
            run(i[0] ? srfa_pkg::SRFA_OP_SETC : srfa_pkg::SRFA_OP_CLRC, 0, 0, 0, 0);
            u_rf.poke(5'(i + 1), (i < 5) ? 8'h81 : 8'h01);
            x = shf(i % 5, (i < 5) ? 8'h81 : 8'h01, st[0]);
            st[3:0] = {x[7] ^ x[8], x[7], x[7:0] == 8'h00, x[8]};
            run(srfa_pkg::srfa_op_t'(5'(i % 5 + 1)), 5'(i + 1), 0, 1, x[7:0]);
        end
        $display("test shifts done");
        u_rf.poke(5'd20, 8'ha5);
        run(srfa_pkg::SRFA_OP_NIBX, 5'd20, 0, 1, 8'h5a);
        op_valid_i = 1'b0;
        @(posedge clk_i);
        #1 chk("written back", 8'h5a, u_rf.mem[20]);
        $display("test nibble exchange done");
        for (int s = 0; s < 8; s++)
        begin
            st[s] = 1'b1;
            run(srfa_pkg::SRFA_OP_BITSET, 0, 3'(s), 0, 0);
            st[s] = 1'b0;
            run(srfa_pkg::SRFA_OP_BITCLR, 0, 3'(s), 0, 0);
        end
        $display("test flag select done");
        // Set codes sit on odd values from 0b, each followed by its clear code
        for (int k = 0; k < 16; k++)
        begin
            st[fpos[k / 2]] = ~k[0];
            run(srfa_pkg::srfa_op_t'(5'(k + 11)), 0, 0, 0, 0);
        end
        $display("test named flags done");
        u_rf.poke(5'd21, 8'h08);
        st[6] = 1'b1;
        run(srfa_pkg::SRFA_OP_TOXFER, 5'd21, 3'h3, 0, 0);
        u_rf.poke(5'd22, 8'h00);
        run(srfa_pkg::SRFA_OP_FRXFER, 5'd22, 3'h0, 1, 8'h01);
        st[6] = 1'b0;
        run(srfa_pkg::SRFA_OP_TOXFER, 5'd21, 3'h2, 0, 0);
        run(srfa_pkg::SRFA_OP_FRXFER, 5'd20, 3'h1, 1, 8'h58);
        st[0] = 1'b1;
        run(srfa_pkg::SRFA_OP_SETC, 0, 0, 0, 0);
        st[0] = 1'b0;
        run(srfa_pkg::SRFA_OP_ROTL, 5'd22, 0, 1, 8'h03);
        $display("test transfer and chaining done");
        run(srfa_pkg::SRFA_OP_NOP, 0, 0, 0, 0);
        op_i = srfa_pkg::srfa_op_t'(5'h1b);
        op_valid_i = 1'b1;
        @(posedge clk_i);
        #1 chk("illegal pulse", 8'h01, {7'h0, op_illegal_o});
        chk("illegal write", 8'h00, {7'h0, dest_wr_o});
        chk("illegal flags", st, flags);
        status_load_i = 1'b1;
        load_data = 8'ha4;
        // Load takes every bit except carry, which the instruction sets
        st = 8'ha5;
        run(srfa_pkg::SRFA_OP_SETC, 0, 0, 0, 0);
        status_load_i = 1'b0;
        chk("load with set carry", 8'ha5, flags);
        $display("test refusal and load done");
        end_of_test();
    end

    initial
    begin
        repeat (3000) @(posedge clk_i);
        n_fail++;
        end_of_test();
    end
endmodule
`default_nettype wire
